// >>> hdl/mipwm_pkg.sv
// shared constants for the multiphase interleaved pwm timing core
package mipwm_pkg;
	localparam int PHASES_MAX = 4;
	localparam int PERIOD_CYC_DEF = 240;
	localparam int SAMPLE_W_DEF = 12;
	localparam logic [2:0] PH_COUNT_RST = 3'h4;
	localparam logic [2:0] PH_COUNT_TWO = 3'h2;
	localparam logic [2:0] PH_COUNT_THREE = 3'h3;
	localparam logic [2:0] PH_COUNT_FOUR = 3'h4;
	// fractions of the switching period, as divisors
	localparam int OFF_DIV = 3;
	localparam int WIN_START_DIV = 6;
	localparam int WIN_LEN_DIV = 3;
	typedef enum logic [1:0] {
		MIPWM_ST_STRAP,
		MIPWM_ST_RUN
	} mipwm_state_t;
endpackage : mipwm_pkg

// >>> hdl/mipwm_channel.sv
// one phase channel: forced off, drive output, sample window and hold
`timescale 1ns/1ps
module mipwm_channel import mipwm_pkg::*; #(
	parameter int PERIOD_CYC = PERIOD_CYC_DEF,
	parameter int SAMPLE_W = SAMPLE_W_DEF,
	parameter int CW = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic active_i,
	input wire logic terminate_i,
	input wire logic ramp_cross_i,
	input wire logic [SAMPLE_W-1:0] current_sense_input_i,
	output logic drive_o,
	output logic window_o,
	output logic [SAMPLE_W-1:0] sample_o,
	output logic sample_valid_o
);
	localparam logic [CW-1:0] OFF_CYC = CW'((PERIOD_CYC + OFF_DIV - 1) / OFF_DIV);
	localparam logic [CW-1:0] WIN_START = CW'((PERIOD_CYC + WIN_START_DIV - 1) / WIN_START_DIV);
	localparam logic [CW-1:0] WIN_END = CW'((PERIOD_CYC + WIN_START_DIV - 1) / WIN_START_DIV + PERIOD_CYC / WIN_LEN_DIV);

	logic drive_ff;
	logic win_ff;
	logic [CW-1:0] off_cnt_ff;
	logic [SAMPLE_W-1:0] sample_ff;
	logic valid_ff;
	// R08 forced off count
	wire off_done = (off_cnt_ff >= OFF_CYC);
	// count runs on past forced off so the window end is reachable
	wire cnt_sat = (off_cnt_ff >= WIN_END);
	wire cnt_at_start = (off_cnt_ff == WIN_START - CW'(1));
	wire cnt_at_end = (off_cnt_ff >= WIN_END - CW'(1));
	// R09 rise after off
	wire rise = active_i && !drive_ff && off_done && ramp_cross_i && !terminate_i;
	// R03 low on terminate
	wire fall = active_i && terminate_i;
	wire [CW-1:0] nxt_off_cnt = fall ? '0 : (cnt_sat ? off_cnt_ff : off_cnt_ff + CW'(1));
	// R10 high until terminate
	wire nxt_drive = fall ? 1'b0 : (rise ? 1'b1 : drive_ff);
	// R11 window timing
	// R12 early close on rise
	wire nxt_win = fall ? 1'b0 : ((cnt_at_start && !drive_ff) ? 1'b1 : ((cnt_at_end || rise) ? 1'b0 : win_ff));
	// R13 hold until next capture
	wire capture = win_ff && !nxt_win;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_ff <= 1'b0;
			win_ff <= 1'b0;
			off_cnt_ff <= '0;
			sample_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			drive_ff <= nxt_drive;
			win_ff <= nxt_win;
			off_cnt_ff <= nxt_off_cnt;
			if (capture) begin
				sample_ff <= current_sense_input_i;
			end
			valid_ff <= (valid_ff || capture) && active_i;
		end
	end
	assign drive_o = drive_ff;
	assign window_o = win_ff;
	assign sample_o = sample_ff;
	assign sample_valid_o = valid_ff;

	// R08 forced off, checked for 8 cycles after each fall
	property p_forced_off;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$fell(drive_ff) |-> !drive_ff [*8];
	endproperty
	a_forced_off: assert property (p_forced_off) else $error("output rose inside forced off"); // R08
	property p_rise_cause;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(drive_ff) |-> $past(ramp_cross_i) && $past(off_done);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("rise without ramp crossing"); // R09
	property p_stay_high;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		drive_ff && !terminate_i |=> drive_ff;
	endproperty
	a_stay_high: assert property (p_stay_high) else $error("output fell without terminate"); // R10
	property p_term_low;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		terminate_i && active_i |=> !drive_ff && !win_ff;
	endproperty
	a_term_low: assert property (p_term_low) else $error("terminate did not force low"); // R03
	property p_win_open;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(win_ff) |-> $past(off_cnt_ff) == WIN_START - CW'(1);
	endproperty
	a_win_open: assert property (p_win_open) else $error("window opened at wrong time"); // R11
	property p_win_rise;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(drive_ff) |-> !win_ff;
	endproperty
	a_win_rise: assert property (p_win_rise) else $error("window open after rise"); // R12
	property p_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!$past(capture) |-> $stable(sample_ff);
	endproperty
	a_hold: assert property (p_hold) else $error("sample changed without capture"); // R13
	c_rise: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(drive_ff));
	c_early: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) win_ff && rise);
	c_full: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) win_ff && cnt_at_end);
endmodule : mipwm_channel

// >>> hdl/mipwm_timing.sv
// top of the multiphase interleaved pwm timing core
`timescale 1ns/1ps
// Summary of operation
// R01: active phases are spaced evenly around the switching period.
// R02: with no strap applied four phases run.
// R03: a termination tick per phase once a period forces that output low.
// R04: each phase cycle starts at its termination tick and lasts one period, up to the next one.
// R05: four phases terminate in order 4,3,2,1 a quarter period apart.
// R06: phase 4 output strapped high gives three phases 3,2,1 a third apart.
// R07: phase 3 output strapped high gives two phases, phase 2 half a period after phase 1.
// R08: after a falling edge an output stays low at least a third of a period.
// R09: after the forced off time an output rises on its ramp crossing input.
// R10: a high output stays high until its next termination tick.
// R11: the sample window opens a sixth period after the fall and lasts at most a third.
// R12: a rising output closes its sample window at once.
// R13: each captured sample is held until the next capture.
// R14: held samples are presented on outputs for balance, load line and overcurrent use.
// R15: the straps are read once, at the end of the first period after reset release, and kept until the next reset.
// R16: ramp crossing inputs arrive already synchronous to the system clock.
module mipwm_timing import mipwm_pkg::*; #(
	parameter int PERIOD_CYC = PERIOD_CYC_DEF,
	parameter int SAMPLE_W = SAMPLE_W_DEF
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic phase3_strap_i,
	input wire logic phase4_strap_i,
	input wire logic [PHASES_MAX-1:0] ramp_cross_i,
	input wire logic [PHASES_MAX*SAMPLE_W-1:0] current_sense_input_i,
	output logic phase1_drive_out_o,
	output logic phase2_drive_out_o,
	output logic phase3_drive_out_o,
	output logic phase4_drive_out_o,
	output logic [PHASES_MAX-1:0] phase_drive_oe_o,
	output logic [PHASES_MAX-1:0] sample_window_o,
	output logic [PHASES_MAX*SAMPLE_W-1:0] held_sample_o,
	output logic [PHASES_MAX-1:0] sample_valid_o,
	output logic [2:0] phase_count_o
);
	localparam int CW = $clog2(PERIOD_CYC + 1) + 1;
	localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
	localparam int QUARTER_CYC = PERIOD_CYC / 4;
	localparam int HALF_CYC = PERIOD_CYC - PERIOD_CYC / 2;

	mipwm_state_t state_ff;
	logic [1:0] s3_meta_ff, s4_meta_ff;
	logic [1:0] s3_sync_ff, s4_sync_ff;
	logic [2:0] count_ff;
	logic [CW-1:0] tick_ff;
	logic [PHASES_MAX-1:0] term_ff;
	logic [PHASES_MAX-1:0] drv;
	logic [PHASES_MAX-1:0] win;
	logic [PHASES_MAX-1:0] vld;
	logic [PHASES_MAX*SAMPLE_W-1:0] smp;

	// straps pass four flops; strap wins over reset default once seen
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s3_meta_ff <= 2'h0;
			s3_sync_ff <= 2'h0;
			s4_meta_ff <= 2'h0;
			s4_sync_ff <= 2'h0;
		end else begin
			s3_meta_ff <= {s3_meta_ff[0], phase3_strap_i};
			s4_meta_ff <= {s4_meta_ff[0], phase4_strap_i};
			s3_sync_ff <= {s3_sync_ff[0], s3_meta_ff[1]};
			s4_sync_ff <= {s4_sync_ff[0], s4_meta_ff[1]};
		end
	end

	// R02 default four phases
	// R06 strap 4 three phases
	// R07 strap 3 two phases
	wire [2:0] strap_count = s3_sync_ff[1] ? PH_COUNT_TWO : (s4_sync_ff[1] ? PH_COUNT_THREE : PH_COUNT_FOUR);

	// R15 sample once
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= MIPWM_ST_STRAP;
			count_ff <= PH_COUNT_RST;
		end else if (state_ff == MIPWM_ST_STRAP && s3_sync_ff[0] == s3_sync_ff[1] && tick_ff == LAST) begin
			state_ff <= MIPWM_ST_RUN;
			count_ff <= strap_count;
		end
	end
	wire running = (state_ff == MIPWM_ST_RUN);

	// R04 one period counter
	wire [CW-1:0] nxt_tick = (tick_ff == LAST) ? '0 : tick_ff + CW'(1);

	// R01 even spacing
	// R05 order 4,3,2,1: phase k fires at (n-k)/n of the period
	function automatic logic fires(input logic [CW-1:0] t, input logic [2:0] n, input int k);
		logic [CW-1:0] slot;
		slot = '0;
		if (k < int'(n)) begin
			slot = CW'((PERIOD_CYC * (int'(n) - 1 - k)) / int'(n));
		end
		return (k < int'(n)) && (t == slot);
	endfunction

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_ff <= '0;
			term_ff <= '0;
		end else begin
			tick_ff <= nxt_tick;
			for (int k = 0; k < PHASES_MAX; k++) begin
				term_ff[k] <= running && fires(tick_ff, count_ff, k);
			end
		end
	end

	// R14 held samples out
	genvar g;
	generate
		for (g = 0; g < PHASES_MAX; g++) begin : g_ch
			mipwm_channel #(
				.PERIOD_CYC(PERIOD_CYC),
				.SAMPLE_W(SAMPLE_W),
				.CW(CW)
			) u_ch (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_n_i),
				.active_i(running && (g < int'(count_ff))),
				.terminate_i(term_ff[g]),
				// R16 ramp input used directly
				.ramp_cross_i(ramp_cross_i[g]),
				.current_sense_input_i(current_sense_input_i[g*SAMPLE_W +: SAMPLE_W]),
				.drive_o(drv[g]),
				.window_o(win[g]),
				.sample_o(smp[g*SAMPLE_W +: SAMPLE_W]),
				.sample_valid_o(vld[g])
			);
		end
	endgenerate

	// outputs of pins 3 and 4 stay released until the strap read is done
	logic [PHASES_MAX-1:0] oe_ff;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oe_ff <= '0;
		end else begin
			for (int k = 0; k < PHASES_MAX; k++) begin
				oe_ff[k] <= running && (k < int'(count_ff));
			end
		end
	end

	assign phase1_drive_out_o = drv[0];
	assign phase2_drive_out_o = drv[1];
	assign phase3_drive_out_o = drv[2];
	assign phase4_drive_out_o = drv[3];
	assign phase_drive_oe_o = oe_ff;
	assign sample_window_o = win;
	assign held_sample_o = smp;
	assign sample_valid_o = vld;
	assign phase_count_o = count_ff;

	property p_order;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		term_ff[3] && count_ff == PH_COUNT_FOUR |-> ##QUARTER_CYC term_ff[2];
	endproperty
	a_order: assert property (p_order) else $error("phase 3 not a quarter after phase 4"); // R05
	property p_two;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		term_ff[0] && count_ff == PH_COUNT_TWO |-> ##HALF_CYC term_ff[1];
	endproperty
	a_two: assert property (p_two) else $error("phase 2 not half after phase 1"); // R07
	property p_fixed;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		running |=> $stable(count_ff);
	endproperty
	a_fixed: assert property (p_fixed) else $error("phase count changed while running"); // R15
	property p_idle4;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		count_ff != PH_COUNT_FOUR |-> !term_ff[3];
	endproperty
	a_idle4: assert property (p_idle4) else $error("inactive phase terminated"); // R06
	c_four: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) running && count_ff == PH_COUNT_FOUR);
	c_three: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) running && count_ff == PH_COUNT_THREE);
endmodule : mipwm_timing

// >>> verif/mipwm_drv_model.sv
// gate driver model: pin level seen by the straps and inductor current per phase
`timescale 1ns/1ps
module mipwm_drv_model import mipwm_pkg::*; #(
	parameter int W = SAMPLE_W_DEF
) (
	input wire logic sys_clk_i,
	input wire logic [3:0] drive_i,
	input wire logic [3:0] oe_i,
	input wire logic [3:0] tie_i,
	output logic [3:0] pin_o,
	output logic [4*W-1:0] sense_o
);
	logic [W-1:0] il_ff [4] = '{default: '0};
	// undriven pin falls to its tie resistor
	assign pin_o = (oe_i & drive_i) | (~oe_i & tie_i);
	// current moves every cycle, so a late capture shows
	always @(posedge sys_clk_i) begin
		for (int k = 0; k < 4; k++) begin
			il_ff[k] <= drive_i[k] ? il_ff[k] + W'(3) : il_ff[k] - W'(1);
		end
	end
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			sense_o[k*W +: W] = il_ff[k];
		end
	end
endmodule : mipwm_drv_model

// >>> verif/mipwm_tb.sv
// self-checking bench for the interleaved pwm timing core
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module testbench import mipwm_pkg::*;;
	localparam int P = 24;
	localparam int W = 12;
	localparam int OFF = (P + OFF_DIV - 1) / OFF_DIV;
	localparam int WS = (P + WIN_START_DIV - 1) / WIN_START_DIV;
	localparam int WL = P / WIN_LEN_DIV;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic arm = 1'b0;
	logic quiet = 1'b0;
	logic [3:0] tie = 4'h0;
	logic [3:0] ramp = 4'h0;
	wire [3:0] pin;
	wire [4*W-1:0] sense;
	logic ph1, ph2, ph3, ph4;
	logic [3:0] oe, win, valid, dp, wp;
	logic [4*W-1:0] held;
	logic [2:0] cnt;
	logic [W-1:0] hp [4], sp [4];
	int n_mismatch, n_checks, cyc, n, last_ch, last_t;
	int fall_t [4], lc [4], wc [4], wf [4], rh [4];
	wire [3:0] d = {ph4, ph3, ph2, ph1};
	always #10 sys_clk_i = ~sys_clk_i;
	mipwm_timing #(.PERIOD_CYC(P), .SAMPLE_W(W)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.phase3_strap_i(pin[2]), .phase4_strap_i(pin[3]), .ramp_cross_i(ramp), .current_sense_input_i(sense),
		.phase1_drive_out_o(ph1), .phase2_drive_out_o(ph2), .phase3_drive_out_o(ph3), .phase4_drive_out_o(ph4),
		.phase_drive_oe_o(oe), .sample_window_o(win), .held_sample_o(held), .sample_valid_o(valid),
		.phase_count_o(cnt));
	mipwm_drv_model #(.W(W)) u_drv (.sys_clk_i(sys_clk_i), .drive_i(d), .oe_i(oe), .tie_i(tie), .pin_o(pin),
		.sense_o(sense));
	always @(posedge sys_clk_i) begin
		#1;
		ramp = quiet ? 4'h0 : 4'($urandom | $urandom);
	end
	function automatic logic [2:0] exp_count(input logic t3, input logic t4);
		return t3 ? PH_COUNT_TWO : (t4 ? PH_COUNT_THREE : PH_COUNT_FOUR);
	endfunction : exp_count
	always @(posedge sys_clk_i) begin
		cyc++;
		if (quiet) begin
			last_ch = -1;
			fall_t = '{default: -1};
		end
		for (int k = 0; k < 4; k++) begin
			lc[k] = (dp[k] && !d[k]) ? 0 : lc[k] + 1;
			wf[k] = (wp[k] && !win[k]) ? 0 : wf[k] + 1;
			if (arm && k >= n) `CHK("idle", 2'h0, {d[k], win[k]})
			if (arm && k < n) begin
				if (dp[k] && !d[k] && fall_t[k] >= 0) `CHK("period", P, cyc - fall_t[k])
				if (dp[k] && !d[k] && last_ch >= 0) `CHK("order", (k + 1) % n, last_ch)
				if (dp[k] && !d[k] && last_ch >= 0) `CHK("spacing", P / n, cyc - last_t)
				if (!dp[k] && d[k]) `CHK("off", 1'b1, lc[k] >= OFF)
				if (!d[k] && fall_t[k] >= 0 && lc[k] >= OFF + 3 && rh[k] >= 3) `CHK("rise", 1'b1, d[k])
				if (!wp[k] && win[k] && fall_t[k] >= 0) `CHK("open", WS, lc[k])
				if (wp[k] && !win[k] && !d[k]) `CHK("length", WL, wc[k])
				if (d[k] && dp[k]) `CHK("close", 1'b0, win[k])
				if (held[k*W +: W] !== hp[k]) `CHK("hold", 1'b1, wf[k] <= 2)
				if (wp[k] && !win[k]) `CHK("sample", sp[k], held[k*W +: W])
				`CHK("valid", 1'b1, valid[k])
				`CHK("enable", 1'b1, oe[k])
			end
			if (dp[k] && !d[k]) begin
				fall_t[k] = cyc;
				last_ch = k;
				last_t = cyc;
			end
			rh[k] = ramp[k] ? rh[k] + 1 : 0;
			wc[k] = win[k] ? wc[k] + 1 : 0;
			hp[k] = held[k*W +: W];
			sp[k] = sense[k*W +: W];
		end
		dp = d;
		wp = win;
	end
	task automatic end_of_test();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic run_cfg(input logic t3, input logic t4);
		int i;
		i = 0;
		arm <= 1'b0;
		#1 rst_n_i = 1'b0;
		tie = {t4, t3, 2'h0};
		n = t3 ? 2 : (t4 ? 3 : 4);
		last_ch = -1;
		fall_t = '{default: -1};
		repeat (4) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		while (oe === 4'h0) begin
			i++;
			if (i > 4 * P) begin
				n_mismatch++;
				end_of_test();
			end
			@(posedge sys_clk_i);
		end
		`CHK("count", exp_count(t3, t4), cnt)
		repeat (2 * P) @(posedge sys_clk_i);
		arm <= 1'b1;
		repeat (8 * P) @(posedge sys_clk_i);
		// long ramp silence gives full-length windows
		quiet <= 1'b1;
		repeat (2 * P) @(posedge sys_clk_i);
		quiet <= 1'b0;
		repeat (P) @(posedge sys_clk_i);
		#1 tie[3:2] = ~tie[3:2];
		repeat (4 * P) @(posedge sys_clk_i);
		`CHK("count_kept", exp_count(t3, t4), cnt)
	endtask : run_cfg
	initial begin
		void'($urandom(32'hCE72));
		for (int c = 0; c < 4; c++) begin
			run_cfg(c[0], c[1]);
		end
		end_of_test();
	end
endmodule : testbench
